// ---- hw/rsd_axil_slave.sv ----
// axi4-lite slave front end: handshakes, responses, address index out
`timescale 1ns/1ps
`default_nettype none

`include "rsd_defines.svh"

module rsd_axil_slave
  import rsd_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire rsd_axil_req_t req,
  output var rsd_axil_rsp_t  rsp,
  output logic [7:0]         rd_index,
  output logic [7:0]         wr_index,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_hit,
  input  wire logic          wr_hit
);

  logic       aw_held_reg;
  logic       w_held_reg;
  logic [7:0] awaddr_reg;
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  logic       rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic       aw_fire;
  logic       w_fire;
  logic       ar_fire;

  assign rsp.awready = !aw_held_reg && !bvalid_reg;
  assign rsp.wready  = !w_held_reg && !bvalid_reg;
  assign rsp.arready = !rvalid_reg;
  assign rsp.bvalid  = bvalid_reg;
  assign rsp.bresp   = bresp_reg;
  assign rsp.rvalid  = rvalid_reg;
  assign rsp.rdata   = rdata_reg;
  assign rsp.rresp   = rresp_reg;

  assign aw_fire  = req.awvalid && rsp.awready;
  assign w_fire   = req.wvalid && rsp.wready;
  assign ar_fire  = req.arvalid && rsp.arready;
  // byte address is four times the register index
  assign rd_index = {2'b00, req.araddr[7:2]};
  assign wr_index = {2'b00, (aw_held_reg ? awaddr_reg[7:2] : req.awaddr[7:2])};

  // ************************************************************
  // write channel: address and data in either order
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (bvalid_reg) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= req.awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
      end
    end
  end

  // data is dropped: every register here is read-only
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RSD_RESP_OKAY;
    end else if (bvalid_reg) begin
      if (req.bready) begin
        bvalid_reg <= 1'b0;
      end
    end else if ((aw_held_reg || aw_fire) && (w_held_reg || w_fire)) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `RSD_RESP_OKAY : `RSD_RESP_DECERR;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RSD_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_data;
      rresp_reg  <= rd_hit ? `RSD_RESP_OKAY : `RSD_RESP_DECERR;
    end else if (rvalid_reg && req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule // rsd_axil_slave

`default_nettype wire

// ---- hw/rsd_defines.svh ----
// register indices, field positions, reset values and bus codes for the status display bank
`ifndef RSD_DEFINES_SVH
`define RSD_DEFINES_SVH

`define RSD_IDX_REG_TIMER   8'h2B
`define RSD_IDX_STRENGTH    8'h2C
`define RSD_IDX_GAIN        8'h2D
`define RSD_ADDR_W          8
`define RSD_DATA_W          32
`define RSD_CODE_W          4

`define RSD_VOLT_HI         7
`define RSD_VOLT_LO         4
`define RSD_GPT_BIT         2
`define RSD_NRT_BIT         1
`define RSD_MRT_BIT         0
`define RSD_AM_HI           7
`define RSD_AM_LO           4
`define RSD_PM_HI           3
`define RSD_PM_LO           0

`define RSD_VOLT_MAX        4'hF
`define RSD_VOLT_MIN        4'h5
`define RSD_STRENGTH_RESET  8'h00
`define RSD_GAIN_RESET      8'h00

`define RSD_RESP_OKAY       2'b00
`define RSD_RESP_DECERR     2'b11

`endif

// ---- hw/rsd_peak_hold.sv ----
// peak-hold register for one receive channel strength code
`timescale 1ns/1ps
`default_nettype none

module rsd_peak_hold
  import rsd_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         clear,
  input  wire logic         meas_valid,
  input  wire logic [W-1:0] meas_code,
  output logic      [W-1:0] peak_reg
);

  // a measurement landing with the clear starts the new peak, so it is not lost
  always_ff @(posedge clock) begin
    if (!rstn) begin
      peak_reg <= '0;
    end else if (clear) begin
      peak_reg <= meas_valid ? meas_code : '0;
    end else if (meas_valid && (meas_code > peak_reg)) begin
      peak_reg <= meas_code;
    end
  end

endmodule // rsd_peak_hold

`default_nettype wire

// ---- hw/rsd_pkg.sv ----
// types shared by the status display bank
`default_nettype none

package rsd_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } rsd_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rsd_axil_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } rsd_meas_t;

  typedef struct packed {
    logic [3:0] prog;
    logic [3:0] squelch;
    logic [3:0] agc;
  } rsd_gain_src_t;

endpackage

`default_nettype wire

// ---- hw/rsd_status_bank.sv ----
// receiver status display bank: regulator/timer, peak strength and gain reduction registers
`timescale 1ns/1ps
`default_nettype none

`include "rsd_defines.svh"

module rsd_status_bank
  import rsd_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire rsd_axil_req_t axil_req,
  output var rsd_axil_rsp_t  axil_rsp,
  input  wire logic          set_default,
  input  wire logic          clear_strength,
  input  wire logic          msg_start,
  input  wire logic          manual_mode,
  input  wire logic [3:0]    manual_volt,
  input  wire logic          adjust_done,
  input  wire logic [3:0]    adjust_code,
  input  wire logic          gpt_running,
  input  wire logic          nrt_running,
  input  wire logic          mrt_running,
  input  wire logic          chan_select,
  input  wire rsd_meas_t     am_meas,
  input  wire rsd_meas_t     pm_meas,
  input  wire rsd_gain_src_t am_gain,
  input  wire rsd_gain_src_t pm_gain,
  output logic [3:0]         selected_strength_reg
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic volt_code_valid(input logic [3:0] code);
    return code >= `RSD_VOLT_MIN;
  endfunction

  // reductions add up; clamp at the largest code rather than wrap
  function automatic logic [3:0] gain_total(input rsd_gain_src_t src);
    logic [5:0] sum;
    sum = {2'b00, src.prog} + {2'b00, src.squelch} + {2'b00, src.agc};
    return (sum > 6'd15) ? 4'hF : sum[3:0];
  endfunction

  function automatic logic is_reg(input logic [7:0] idx);
    return (idx == `RSD_IDX_REG_TIMER) || (idx == `RSD_IDX_STRENGTH) || (idx == `RSD_IDX_GAIN);
  endfunction

  logic [3:0]  auto_volt_reg;
  logic [3:0]  volt_reg;
  logic [2:0]  timer_reg;
  logic [3:0]  am_peak_reg;
  logic [3:0]  pm_peak_reg;
  logic [7:0]  gain_reg;
  logic        peak_clear;
  logic [7:0]  rd_index;
  logic [7:0]  wr_index;
  logic [31:0] rd_data;
  logic [7:0]  regtim_view;

  // ************************************************************
  // regulator voltage code
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      auto_volt_reg <= `RSD_VOLT_MAX;
    end else if (set_default) begin
      auto_volt_reg <= `RSD_VOLT_MAX;
    end else if (adjust_done && volt_code_valid(adjust_code)) begin
      auto_volt_reg <= adjust_code;
    end
  end

  // manual field is reported as written, even an unused code
  always_ff @(posedge clock) begin
    if (!rstn) begin
      volt_reg <= `RSD_VOLT_MAX;
    end else if (set_default) begin
      volt_reg <= `RSD_VOLT_MAX;
    end else begin
      volt_reg <= manual_mode ? manual_volt : auto_volt_reg;
    end
  end

  // ************************************************************
  // timer running flags, mirror of live timer state
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      timer_reg <= 3'b000;
    end else begin
      timer_reg[`RSD_GPT_BIT] <= gpt_running;
      timer_reg[`RSD_NRT_BIT] <= nrt_running;
      timer_reg[`RSD_MRT_BIT] <= mrt_running;
    end
  end

  // ************************************************************
  // peak strength per channel
  // ************************************************************
  assign peak_clear = msg_start || clear_strength || set_default;

  rsd_peak_hold #(.W(`RSD_CODE_W)) u_am_peak (
    .clock      (clock),
    .rstn       (rstn),
    .clear      (peak_clear),
    .meas_valid (am_meas.valid),
    .meas_code  (am_meas.code),
    .peak_reg   (am_peak_reg)
  );

  rsd_peak_hold #(.W(`RSD_CODE_W)) u_pm_peak (
    .clock      (clock),
    .rstn       (rstn),
    .clear      (peak_clear),
    .meas_valid (pm_meas.valid),
    .meas_code  (pm_meas.code),
    .peak_reg   (pm_peak_reg)
  );

  // only the selected channel feeds the rest of the receiver
  always_ff @(posedge clock) begin
    if (!rstn) begin
      selected_strength_reg <= 4'h0;
    end else begin
      selected_strength_reg <= chan_select ? pm_peak_reg : am_peak_reg;
    end
  end

  // ************************************************************
  // second-stage gain reduction
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gain_reg <= `RSD_GAIN_RESET;
    end else if (set_default) begin
      gain_reg <= `RSD_GAIN_RESET;
    end else begin
      gain_reg[`RSD_AM_HI:`RSD_AM_LO] <= gain_total(am_gain);
      gain_reg[`RSD_PM_HI:`RSD_PM_LO] <= gain_total(pm_gain);
    end
  end

  // ************************************************************
  // register bus
  // ************************************************************
  assign regtim_view = {volt_reg, 1'b0, timer_reg};

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_index)
      `RSD_IDX_REG_TIMER: rd_data[7:0] = regtim_view;
      `RSD_IDX_STRENGTH:  rd_data[7:0] = {am_peak_reg, pm_peak_reg};
      `RSD_IDX_GAIN:      rd_data[7:0] = gain_reg;
      default:            rd_data = 32'h0000_0000;
    endcase
  end

  // writes land nowhere; reads only sample state
  rsd_axil_slave u_bus (
    .clock    (clock),
    .rstn     (rstn),
    .req      (axil_req),
    .rsp      (axil_rsp),
    .rd_index (rd_index),
    .wr_index (wr_index),
    .rd_data  (rd_data),
    .rd_hit   (is_reg(rd_index)),
    .wr_hit   (is_reg(wr_index))
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic       ar_take;
  logic [7:0] ar_idx_q;
  logic [7:0] ar_val_q;
  assign ar_take = axil_req.arvalid && axil_rsp.arready;

  // captured at the address edge, so the held answer can be judged against it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ar_idx_q <= 8'h00;
      ar_val_q <= 8'h00;
    end else if (ar_take) begin
      ar_idx_q <= rd_index;
      ar_val_q <= rd_data[7:0];
    end
  end

  unused_bit_a: assert property (
    ar_take && (rd_index == `RSD_IDX_REG_TIMER) |=> (axil_rsp.rdata[3] == 1'b0)
      && (axil_rsp.rdata[7:4] == $past(volt_reg)))
    else $error("regulator status read shows bad voltage field or bit 3");

  invalid_adjust_a: assert property (
    adjust_done && !volt_code_valid(adjust_code) && !set_default |=> $stable(auto_volt_reg))
    else $error("unused adjust code was taken");

  default_volt_a: assert property (
    set_default |=> (volt_reg == `RSD_VOLT_MAX) && (auto_volt_reg == `RSD_VOLT_MAX))
    else $error("voltage not at maximum after set-default");

  timer_flags_a: assert property (
    ##1 timer_reg == {$past(gpt_running), $past(nrt_running), $past(mrt_running)})
    else $error("timer running flags do not follow timers");

  peak_read_a: assert property (
    ar_take && (rd_index == `RSD_IDX_STRENGTH) |=> axil_rsp.rvalid
      && (axil_rsp.rdata == {24'h00_0000, $past(am_peak_reg), $past(pm_peak_reg)}))
    else $error("strength read does not match peak fields");

  peak_hold_a: assert property (
    !peak_clear |=> (am_peak_reg >= $past(am_peak_reg)) && (pm_peak_reg >= $past(pm_peak_reg)))
    else $error("peak value fell without a clear");

  peak_clear_a: assert property (
    (msg_start || clear_strength) && !am_meas.valid && !pm_meas.valid
      |=> (am_peak_reg == 4'h0) && (pm_peak_reg == 4'h0))
    else $error("peak fields not cleared");

  gain_default_a: assert property (
    set_default |=> (gain_reg == 8'h00) ##1 (selected_strength_reg == 4'h0 || $past(am_meas.valid, 2)
      || $past(pm_meas.valid, 2)))
    else $error("gain or strength not zero after set-default");

  chan_pick_a: assert property (
    ##1 selected_strength_reg == ($past(chan_select) ? $past(pm_peak_reg) : $past(am_peak_reg)))
    else $error("selected strength from wrong channel");

  gain_sum_a: assert property (
    !set_default |=> gain_reg == {gain_total($past(am_gain)), gain_total($past(pm_gain))})
    else $error("gain reduction is not the combined value");

  manual_volt_a: assert property (
    manual_mode && !set_default |=> volt_reg == $past(manual_volt))
    else $error("manual voltage not reported");

  ro_write_a: assert property (
    $rose(axil_rsp.bvalid) |-> axil_rsp.bresp == (is_reg($past(wr_index)) ? `RSD_RESP_OKAY : `RSD_RESP_DECERR))
    else $error("write response wrong");

  read_stable_a: assert property (
    axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
    else $error("read answer dropped before rready");

  peak_rise_am_a: assert property (
    am_meas.valid && !peak_clear && (am_meas.code > am_peak_reg) |=> am_peak_reg == $past(am_meas.code))
    else $error("AM peak did not take a larger measurement");

  peak_rise_pm_a: assert property (
    pm_meas.valid && !peak_clear && (pm_meas.code > pm_peak_reg) |=> pm_peak_reg == $past(pm_meas.code))
    else $error("PM peak did not take a larger measurement");

  strength_default_a: assert property (
    set_default && !am_meas.valid && !pm_meas.valid |=> {am_peak_reg, pm_peak_reg} == `RSD_STRENGTH_RESET)
    else $error("strength not zero after set-default");

  auto_volt_a: assert property (
    !manual_mode && !set_default |=> volt_reg == $past(auto_volt_reg))
    else $error("automatic voltage not reported");

  volt_range_a: assert property (
    auto_volt_reg >= `RSD_VOLT_MIN)
    else $error("stored adjust result is an unused code");

  read_data_a: assert property (
    axil_rsp.rvalid |-> (axil_rsp.rdata == {24'h00_0000, ar_val_q})
      && (axil_rsp.rresp == (is_reg(ar_idx_q) ? `RSD_RESP_OKAY : `RSD_RESP_DECERR)))
    else $error("read answer differs from the register sampled at the address edge");

  manual_seen_c:  cover property (manual_mode ##1 !manual_mode);
  peak_rise_c:    cover property (am_meas.valid ##1 (am_peak_reg != 4'h0) ##[1:20] msg_start);
  read_gain_c:    cover property (ar_take && rd_index == `RSD_IDX_GAIN);
  write_seen_c:   cover property ($rose(axil_rsp.bvalid));
  default_seen_c: cover property (set_default ##1 (volt_reg == `RSD_VOLT_MAX));

endmodule // rsd_status_bank

`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the receiver status display bank
`timescale 1ns/1ps
`default_nettype none

`include "rsd_defines.svh"

module tb_top
  import rsd_pkg::*;
;
  // ****************************************
  // signals and bench state
  // ****************************************
  localparam logic [7:0] A_REG = 8'(`RSD_IDX_REG_TIMER * 4);
  localparam logic [7:0] A_STR = 8'(`RSD_IDX_STRENGTH * 4);
  localparam logic [7:0] A_GAIN = 8'(`RSD_IDX_GAIN * 4);

  logic          clock = 1'b0;
  logic          rstn = 1'b0;
  rsd_axil_req_t req = '0;
  rsd_axil_rsp_t rsp;
  logic          set_default = 1'b0;
  logic          clear_strength = 1'b0;
  logic          msg_start = 1'b0;
  logic          manual_mode = 1'b0;
  logic [3:0]    manual_volt = 4'h0;
  logic          adjust_done = 1'b0;
  logic [3:0]    adjust_code = 4'h0;
  logic          gpt_running = 1'b0;
  logic          nrt_running = 1'b0;
  logic          mrt_running = 1'b0;
  logic          chan_select = 1'b0;
  rsd_meas_t     am_meas = '0;
  rsd_meas_t     pm_meas = '0;
  rsd_gain_src_t am_gain = '0;
  rsd_gain_src_t pm_gain = '0;
  logic [3:0]    selected_strength_reg;
  int            err_total = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  logic [34:0]   exp_q[$];
  logic [34:0]   mon_e;
  logic [3:0]    am_max;
  logic [3:0]    pm_max;
  logic [3:0]    volt;

  rsd_status_bank i_dut (
    .clock                 (clock),
    .rstn                  (rstn),
    .axil_req              (req),
    .axil_rsp              (rsp),
    .set_default           (set_default),
    .clear_strength        (clear_strength),
    .msg_start             (msg_start),
    .manual_mode           (manual_mode),
    .manual_volt           (manual_volt),
    .adjust_done           (adjust_done),
    .adjust_code           (adjust_code),
    .gpt_running           (gpt_running),
    .nrt_running           (nrt_running),
    .mrt_running           (mrt_running),
    .chan_select           (chan_select),
    .am_meas               (am_meas),
    .pm_meas               (pm_meas),
    .am_gain               (am_gain),
    .pm_gain               (pm_gain),
    .selected_strength_reg (selected_strength_reg)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  // ****************************************
  // checking and verdict
  // ****************************************
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // generous ceiling, the sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // responses are matched against the oldest note, one transfer at a time
  always @(posedge clock) begin
    if (rstn && rsp.rvalid && req.rready) begin
      mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 35'h0_0000_0000;
      check("read kind", {33'h0, mon_e[34]}, 34'h1);
      check("read response", {rsp.rresp, rsp.rdata}, mon_e[33:0]);
    end
    if (rstn && rsp.bvalid && req.bready) begin
      mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 35'h4_0000_0000;
      check("write kind", {33'h0, mon_e[34]}, 34'h0);
      check("write response", {rsp.bresp, 32'h0}, mon_e[33:0]);
    end
  end

  // ****************************************
  // bus and stimulus tasks
  // ****************************************
  task automatic axi_read(input logic [7:0] addr, input logic [33:0] exp);
    bit done;
    done = 1'b0;
    @(posedge clock);
    exp_q.push_back({1'b1, exp});
    req.arvalid <= 1'b1;
    req.araddr <= addr;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (rsp.arready === 1'b1) begin
        done = 1'b1;
        req.arvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask

  task automatic rd8(input logic [7:0] addr, input logic [7:0] v);
    axi_read(addr, {2'b00, 24'h00_0000, v});
  endtask

  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    exp_q.push_back({1'b0, resp, 32'h0000_0000});
    req.awvalid <= 1'b1;
    req.awaddr <= addr;
    req.wvalid <= 1'b1;
    req.wdata <= data;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (!aw_done && rsp.awready === 1'b1) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_done && rsp.wready === 1'b1) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask

  // sel: {set_default, clear_strength, msg_start}
  task automatic pulse_cmd(input logic [2:0] sel);
    @(posedge clock);
    {set_default, clear_strength, msg_start} <= sel;
    @(posedge clock);
    {set_default, clear_strength, msg_start} <= 3'h0;
    if (sel != 3'h0) begin
      am_max = 4'h0;
      pm_max = 4'h0;
    end
  endtask

  task automatic set_adjust(input logic [3:0] code);
    @(posedge clock);
    adjust_done <= 1'b1;
    adjust_code <= code;
    @(posedge clock);
    adjust_done <= 1'b0;
    if (code >= `RSD_VOLT_MIN) volt = code;
  endtask

  task automatic send_meas(input logic [3:0] a, input logic [3:0] p);
    @(posedge clock);
    am_meas <= '{valid: 1'b1, code: a};
    pm_meas <= '{valid: 1'b1, code: p};
    @(posedge clock);
    am_meas.valid <= 1'b0;
    pm_meas.valid <= 1'b0;
    if (a > am_max) am_max = a;
    if (p > pm_max) pm_max = p;
  endtask

  function automatic logic [3:0] gsum(input rsd_gain_src_t g);
    int s;
    s = int'(g.prog) + int'(g.squelch) + int'(g.agc);
    return (s > 15) ? 4'hf : 4'(s);
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h85cf));
    am_max = 4'h0;
    pm_max = 4'h0;
    volt = `RSD_VOLT_MAX;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rd8(A_REG, 8'hf0);
    rd8(A_STR, 8'h00);
    rd8(A_GAIN, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      {gpt_running, nrt_running, mrt_running} <= 3'(i);
      repeat (2) @(posedge clock);
      rd8(A_REG, {volt, 1'b0, 3'(i)});
    end
    for (int c = 5; c < 16; c++) begin
      set_adjust(4'(c));
      rd8(A_REG, {volt, 4'h7});
    end
    set_adjust(4'h3);
    rd8(A_REG, {volt, 4'h7});
    @(posedge clock);
    manual_mode <= 1'b1;
    manual_volt <= 4'($urandom_range(5, 15));
    repeat (2) @(posedge clock);
    rd8(A_REG, {manual_volt, 4'h7});
    @(posedge clock);
    manual_mode <= 1'b0;
    set_adjust(4'h7);
    rd8(A_REG, {4'h7, 4'h7});
    // nonzero gain, so the set-default below has something to clear
    am_gain <= '{prog: 4'h3, squelch: 4'h2, agc: 4'h1};
    for (int n = 0; n < 3; n++) begin
      repeat (12) send_meas(4'($urandom % 16), 4'($urandom % 10));
      send_meas(4'h1, 4'h0);
      rd8(A_STR, {am_max, pm_max});
      rd8(A_STR, {am_max, pm_max});
      for (int s = 0; s < 2; s++) begin
        @(posedge clock);
        chan_select <= 1'(s);
        repeat (3) @(posedge clock);
        check("selected strength", {30'h0, selected_strength_reg}, {30'h0, s ? pm_max : am_max});
      end
      axi_write(A_STR, 32'hffff_ffff, `RSD_RESP_OKAY);
      rd8(A_STR, {am_max, pm_max});
      pulse_cmd(3'b001 << n);
      rd8(A_STR, 8'h00);
    end
    rd8(A_REG, 8'hf7);
    for (int g = 0; g < 8; g++) begin
      @(posedge clock);
      am_gain <= '{prog: 4'($urandom % 8), squelch: 4'($urandom % 6), agc: 4'($urandom % 5)};
      pm_gain <= '{prog: 4'($urandom % 5), squelch: 4'($urandom % 8), agc: 4'($urandom % 6)};
      repeat (3) @(posedge clock);
      rd8(A_GAIN, {gsum(am_gain), gsum(pm_gain)});
    end
    axi_write(A_GAIN, 32'h0000_0000, `RSD_RESP_OKAY);
    axi_write(A_REG, 32'h0000_00ff, `RSD_RESP_OKAY);
    rd8(A_GAIN, {gsum(am_gain), gsum(pm_gain)});
    rd8(A_REG, 8'hf7);
    axi_read(8'h04, {`RSD_RESP_DECERR, 32'h0000_0000});
    axi_write(8'h04, 32'h1234_5678, `RSD_RESP_DECERR);
    repeat (4) @(posedge clock);
    check("pending notes", 34'(exp_q.size()), 34'h0);
    give_verdict();
  end

endmodule // tb_top

`default_nettype wire
